// ---- rtl/plsc_low_speed_ctrl.v ----
`timescale 1ns/100ps
`include "plsc_defs.vh"
module plsc_low_speed_ctrl #(
  parameter integer RESET_MIN_CYC = `PLSC_RESET_MIN_CYC,
  parameter integer INIT_CYC      = `PLSC_INIT_CYC,
  parameter integer LANES         = 4
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire             bus_select_n_i,
  input  wire             hard_restart_n_i,
  input  wire             power_cap_pin_i,
  input  wire             scl_i,
  input  wire             sda_i,
  input  wire             fault_i,
  output wire             sda_o,
  output wire             sda_oe_o,
  output wire             presence_n_o,
  output wire             presence_n_oe_o,
  output wire             alert_n_o,
  output wire             alert_n_oe_o,
  output reg  [LANES-1:0] tx_lane_off_o,
  output reg  [LANES-1:0] rx_lane_off_o,
  output reg              high_power_o,
  output reg              init_pending_o
);
  localparam [2:0] M_INIT = 3'b001;
  localparam [2:0] M_RUN  = 3'b010;
  localparam [2:0] M_RST  = 3'b100;

  reg  [2:0]  mode;
  reg  [1:0]  sel_s;
  reg  [1:0]  rst_s;
  reg  [1:0]  cap_s;
  reg  [1:0]  flt_s;
  reg  [15:0] low_cnt;
  reg  [15:0] init_cnt;
  reg         done_flag;
  reg         fault_flag;
  reg  [7:0]  lane_off;
  reg  [7:0]  power_ctl;
  reg  [7:0]  rdata;
  reg         soft_rst;
  wire [7:0]  addr;
  wire [7:0]  wdata;
  wire        wr;
  wire        rd;
  wire        long_low = (low_cnt >= RESET_MIN_CYC[15:0]);
  reg         alert_q;
  wire [3:0]  hit;
  wire        flags_rd;
  wire        init_last;
  wire        start_rst;

  // ==========================================================
  // one-hot decode of the memory map pointer
  function [3:0] map_hit;
    input [7:0] a;
    begin
      if (a == `PLSC_ADDR_STATUS)
        map_hit = 4'h1;
      else if (a == `PLSC_ADDR_FLAGS)
        map_hit = 4'h2;
      else if (a == `PLSC_ADDR_LANE_OFF)
        map_hit = 4'h4;
      else if (a == `PLSC_ADDR_POWER)
        map_hit = 4'h8;
      else
        map_hit = 4'h0;
    end
  endfunction

  // ==========================================================
  // shared decodes; start_rst lets lanes and slave drop in the same cycle
  assign hit       = map_hit(addr);
  assign flags_rd  = rd & hit[1];
  assign init_last = (mode == M_INIT) && (init_cnt >= INIT_CYC[15:0] - 16'h0001);
  assign start_rst = (mode == M_RUN) && !rst_s[1] && long_low;

  // ==========================================================
  // pin synchronisers
  always @(posedge clock_i) begin
    sel_s <= {sel_s[0], bus_select_n_i};
    rst_s <= {rst_s[0], hard_restart_n_i};
    cap_s <= {cap_s[0], power_cap_pin_i};
    flt_s <= {flt_s[0], fault_i};
  end

  // ==========================================================
  // serial slave enabled by select, idle during reset
  plsc_serial_slave u_slave (
    .clock_i  (clock_i),
    .reset_i  (reset_i | soft_rst),
    .enable_i (~sel_s[1] & ~init_pending_o & ~start_rst),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_oe_o (sda_oe_o),
    .addr_o   (addr),
    .wdata_o  (wdata),
    .wr_o     (wr),
    .rd_o     (rd),
    .rdata_i  (rdata)
  );
  assign sda_o = 1'b0;

  // ==========================================================
  // restart pulse width and init sequencing
  always @(posedge clock_i) begin
    soft_rst <= 1'b0;
    if (reset_i) begin
      mode           <= M_INIT;
      low_cnt        <= 16'h0000;
      init_cnt       <= 16'h0000;
      init_pending_o <= 1'b1;
    end else begin
      if (rst_s[1]) low_cnt <= 16'h0000;
      else if (!long_low) low_cnt <= low_cnt + 16'h0001;
      case (mode)
        M_INIT: begin
          if (init_last) begin
            mode           <= M_RUN;
            init_pending_o <= 1'b0;
          end else begin
            init_cnt <= init_cnt + 16'h0001;
          end
        end
        M_RUN: begin
          if (start_rst) begin
            mode           <= M_RST;
            soft_rst       <= 1'b1;
            init_pending_o <= 1'b1;
          end
        end
        M_RST: begin
          soft_rst <= 1'b1;
          init_cnt <= 16'h0000;
          if (rst_s[1]) mode <= M_INIT;
        end
        default: mode <= M_INIT;
      endcase
    end
  end

  // ==========================================================
  // sticky sources; set wins over read clear
  always @(posedge clock_i) begin
    if (reset_i) begin
      done_flag  <= 1'b0;
      fault_flag <= 1'b0;
    end else begin
      if (init_last) done_flag <= 1'b1;
      else if (flags_rd) done_flag <= 1'b0;
      if (flt_s[1]) fault_flag <= 1'b1;
      else if (flags_rd) fault_flag <= 1'b0;
    end
  end

  // ==========================================================
  // control registers, default on any reset
  always @(posedge clock_i) begin
    if (reset_i || soft_rst) begin
      lane_off  <= `PLSC_LANE_OFF_RST;
      power_ctl <= `PLSC_POWER_RST;
    end else if (wr) begin
      if (hit[2]) lane_off <= wdata;
      else if (hit[3]) power_ctl <= wdata;
    end
  end

  // ==========================================================
  // lane and power outputs
  always @(posedge clock_i) begin
    if (reset_i) begin
      tx_lane_off_o <= {LANES{1'b1}};
      rx_lane_off_o <= {LANES{1'b1}};
      high_power_o  <= 1'b0;
    end else begin
      tx_lane_off_o <= lane_off[LANES-1:0] | {LANES{init_pending_o | start_rst}};
      rx_lane_off_o <= lane_off[2*LANES-1:LANES] | {LANES{init_pending_o | start_rst}};
      high_power_o  <= power_ctl[`PLSC_PW_OVERRIDE] ?
                       power_ctl[`PLSC_PW_HIGH_EN] : ~cap_s[1];
    end
  end

  // ==========================================================
  // read data mux
  always @* begin
    if (addr == `PLSC_ADDR_STATUS)
      rdata = {6'h00, cap_s[1], init_pending_o};
    else if (addr == `PLSC_ADDR_FLAGS)
      rdata = {6'h00, fault_flag, done_flag};
    else if (addr == `PLSC_ADDR_LANE_OFF)
      rdata = lane_off;
    else if (addr == `PLSC_ADDR_POWER)
      rdata = power_ctl;
    else
      rdata = 8'h00;
  end

  // ==========================================================
  // registered alert request from the sticky sources
  always @(posedge clock_i) begin
    if (reset_i) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= done_flag | fault_flag;
    end
  end

  // ==========================================================
  // open-collector pins
  assign alert_n_o       = 1'b0;
  assign alert_n_oe_o    = alert_q;
  assign presence_n_o    = 1'b0;
  assign presence_n_oe_o = 1'b1;
endmodule // plsc_low_speed_ctrl

// ---- rtl/plsc_defs.vh ----
`ifndef PLSC_DEFS_VH
`define PLSC_DEFS_VH
// ==========================================================
// memory map byte offsets
`define PLSC_ADDR_STATUS     8'h02
`define PLSC_ADDR_FLAGS      8'h03
`define PLSC_ADDR_LANE_OFF   8'h56
`define PLSC_ADDR_POWER      8'h5D
// ==========================================================
// field positions
`define PLSC_ST_NOT_READY    0
`define PLSC_ST_POWER_CAP    1
`define PLSC_FL_RESET_DONE   0
`define PLSC_PW_OVERRIDE     0
`define PLSC_PW_HIGH_EN      1
// ==========================================================
// reset values
`define PLSC_LANE_OFF_RST    8'h00
`define PLSC_POWER_RST       8'h00
// ==========================================================
// timing counts
`define PLSC_RESET_MIN_CYC   100
`define PLSC_INIT_CYC        200
// ==========================================================
// two-wire device address, arbitrary default
`define PLSC_DEV_ADDR        7'h50
`endif

// ---- rtl/plsc_serial_slave.v ----
`timescale 1ns/100ps
`include "plsc_defs.vh"
// ==========================================================
// two-wire serial slave, sampled on the module clock
module plsc_serial_slave #(
  parameter [6:0] DEV_ADDR = `PLSC_DEV_ADDR
) (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire       enable_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_oe_o,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o,
  input  wire [7:0] rdata_i
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_DEV  = 7'h02;
  localparam [6:0] S_ACK  = 7'h04;
  localparam [6:0] S_ADR  = 7'h08;
  localparam [6:0] S_WR   = 7'h10;
  localparam [6:0] S_RD   = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  reg [6:0] state;
  reg [6:0] ack_next;
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [7:0] shift;
  reg [3:0] bits;
  reg       is_read;
  reg       have_addr;
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c  = scl_s[1] & sda_s[2] & ~sda_s[1];
  wire stop_c   = scl_s[1] & ~sda_s[2] & sda_s[1];

  // ==========================================================
  // two-stage synchronisers, third stage for edges
  always @(posedge clock_i) begin
    scl_s <= {scl_s[1:0], scl_i};
    sda_s <= {sda_s[1:0], sda_i};
  end

  // ==========================================================
  // byte framing, address match, ack and data shifting
  always @(posedge clock_i) begin
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    if (reset_i || !enable_i || stop_c) begin
      state     <= S_IDLE;
      sda_oe_o  <= 1'b0;
      have_addr <= 1'b0;
      if (reset_i) begin
        addr_o  <= 8'h00;
        wdata_o <= 8'h00;
        shift   <= 8'h00;
        bits    <= 4'h0;
        is_read <= 1'b0;
        ack_next <= S_IDLE;
      end
    end else if (start_c) begin
      state     <= S_DEV;
      bits      <= 4'h0;
      sda_oe_o  <= 1'b0;
      have_addr <= 1'b0;
    end else begin
      case (state)
        S_DEV, S_ADR, S_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s[1]};
            bits  <= bits + 4'h1;
          end
          if (scl_fall && bits == 4'h8) begin
            bits <= 4'h0;
            if (state == S_DEV) begin
              if (shift[7:1] == DEV_ADDR) begin
                is_read  <= shift[0];
                sda_oe_o <= 1'b1;
                ack_next <= shift[0] ? S_RD : S_ADR;
                state    <= S_ACK;
              end else begin
                state <= S_IDLE;
              end
            end else if (state == S_ADR) begin
              addr_o   <= shift;
              sda_oe_o <= 1'b1;
              ack_next <= S_WR;
              state    <= S_ACK;
            end else begin
              wdata_o  <= shift;
              wr_o     <= 1'b1;
              sda_oe_o <= 1'b1;
              ack_next <= S_WR;
              state    <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            state <= ack_next;
            if (is_read) begin
              rd_o     <= 1'b1;
              shift    <= rdata_i;
              sda_oe_o <= ~rdata_i[7];
              bits     <= 4'h1;
            end else begin
              sda_oe_o <= 1'b0;
            end
            if (ack_next == S_WR && have_addr) addr_o <= addr_o + 8'h01;
            if (ack_next == S_WR) have_addr <= 1'b1;
          end
        end
        S_RD: begin
          if (scl_fall) begin
            if (bits == 4'h8) begin
              sda_oe_o <= 1'b0;
              bits     <= 4'h0;
              state    <= S_RACK;
              addr_o   <= addr_o + 8'h01;
            end else begin
              sda_oe_o <= ~shift[6];
              shift    <= {shift[6:0], 1'b0};
              bits     <= bits + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise && sda_s[1]) state <= S_IDLE;
          if (scl_fall) begin
            rd_o     <= 1'b1;
            shift    <= rdata_i;
            sda_oe_o <= ~rdata_i[7];
            bits     <= 4'h1;
            state    <= S_RD;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // plsc_serial_slave

// ---- test/plsc_low_speed_ctrl_checker.sv ----
`timescale 1ns/100ps
// ==========================================================
// port checker
module plsc_low_speed_ctrl_checker #(
  parameter integer RESET_MIN_CYC = 100,
  parameter integer INIT_CYC      = 200,
  parameter integer LANES         = 4
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire             bus_select_n_i,
  input  wire             hard_restart_n_i,
  input  wire             sda_o,
  input  wire             sda_oe_o,
  input  wire             presence_n_o,
  input  wire             presence_n_oe_o,
  input  wire             alert_n_o,
  input  wire             alert_n_oe_o,
  input  wire [LANES-1:0] tx_lane_off_o,
  input  wire [LANES-1:0] rx_lane_off_o,
  input  wire             init_pending_o
);
  reg [15:0] low_cnt;
  reg        was_high;
  // length of the latest low run on the restart pin, kept after release
  always @(posedge clock_i) begin
    if (reset_i) begin
      low_cnt  <= 16'h0000;
      was_high <= 1'b1;
    end else if (hard_restart_n_i) begin
      was_high <= 1'b1;
    end else begin
      was_high <= 1'b0;
      low_cnt  <= was_high ? 16'h0001 : ((low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001);
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  AST_SELECT: assert property (bus_select_n_i [*8] |-> !sda_oe_o)
    else $error("data line driven while deselected");
  AST_PEND_SDA: assert property (init_pending_o |-> !sda_oe_o)
    else $error("data line driven while initialising");
  AST_SDA_LOW: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_ALERT_OC: assert property (alert_n_o == 1'b0)
    else $error("alert line driven high");
  AST_PRESENT: assert property (presence_n_oe_o && (presence_n_o == 1'b0))
    else $error("presence line not grounded");
  AST_LANES: assert property (init_pending_o |-> (&tx_lane_off_o) && (&rx_lane_off_o))
    else $error("lane on while initialising");
  AST_INIT_DONE: assert property ($fell(init_pending_o) |-> ##[0:2] alert_n_oe_o)
    else $error("no alert at end of initialisation");
  AST_RESTART: assert property (!hard_restart_n_i && low_cnt == RESET_MIN_CYC + 3 |-> ##[0:3] init_pending_o)
    else $error("long restart pulse ignored");
  AST_SHORT: assert property ($rose(init_pending_o) |-> low_cnt >= RESET_MIN_CYC)
    else $error("restart on short pulse");
endmodule // plsc_low_speed_ctrl_checker

// ---- test/plsc_host_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// host controller, 160 ns bit time, clock stands high between frames
module plsc_host_model #(
  parameter [6:0] DEV_ADDR = 7'h50
) (
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_low_o,
  output reg  select_n_o
);
  reg s;
  // idle: lines released, module deselected
  initial begin
    scl_o      = 1'b1;
    sda_low_o  = 1'b0;
    select_n_o = 1'b1;
  end
  // one bit: data set while clock low, sampled while high
  task bitx(input b);
    begin
      #40 sda_low_o = !b;
      #40 scl_o = 1'b1;
      #40 s = sda_i;
      #40 scl_o = 1'b0;
    end
  endtask
  // start or repeated start
  task start;
    begin
      sda_low_o = 1'b0;
      #40 scl_o = 1'b1;
      #40 sda_low_o = 1'b1;
      #40 scl_o = 1'b0;
    end
  endtask
  task wbyte(input [7:0] d, inout ok);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i]);
      bitx(1'b1);
      ok = ok & !s;
    end
  endtask
  // one register access, each module has its own select line
  task xfer(input sel, input [7:0] a, input wr, input [7:0] wd, output [7:0] rd, output ok);
    integer i;
    begin
      ok = 1'b1;
      select_n_o = !sel;
      start;
      wbyte({DEV_ADDR, 1'b0}, ok);
      wbyte(a, ok);
      if (wr) begin
        wbyte(wd, ok);
      end else begin
        start;
        wbyte({DEV_ADDR, 1'b1}, ok);
        for (i = 7; i >= 0; i = i - 1) begin
          bitx(1'b1);
          rd[i] = s;
        end
        bitx(1'b1);
      end
      #40 sda_low_o = 1'b1;
      #40 scl_o = 1'b1;
      #40 sda_low_o = 1'b0;
      #40 select_n_o = 1'b1;
      #160;
    end
  endtask
endmodule // plsc_host_model

// ---- test/plsc_low_speed_ctrl_tb.sv ----
`timescale 1ns/100ps
`include "plsc_defs.vh"
// ==========================================================
// bench top
module plsc_low_speed_ctrl_tb;
  localparam integer RMIN = 10;
  reg        clock_i, reset_i, hard_restart_n_i, power_cap_pin_i, fault_i;
  wire       sda_o, sda_oe_o, pres_n, pres_oe, alert_o, alert_oe, high_power_o, init_pending_o;
  wire       scl, sda_low, select_n;
  wire [3:0] tx_off, rx_off;
  wire       sda_line   = !(sda_oe_o || sda_low);
  wire       alert_line = !alert_oe;
  reg  [7:0] rd;
  reg        ok;
  integer    n_fail, check_count, i;
  plsc_low_speed_ctrl #(.RESET_MIN_CYC(RMIN), .INIT_CYC(20), .LANES(4)) dut_u (.clock_i(clock_i),
    .reset_i(reset_i), .bus_select_n_i(select_n), .hard_restart_n_i(hard_restart_n_i),
    .power_cap_pin_i(power_cap_pin_i), .scl_i(scl), .sda_i(sda_line), .fault_i(fault_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .presence_n_o(pres_n), .presence_n_oe_o(pres_oe), .alert_n_o(alert_o),
    .alert_n_oe_o(alert_oe), .tx_lane_off_o(tx_off), .rx_lane_off_o(rx_off), .high_power_o(high_power_o),
    .init_pending_o(init_pending_o));
  plsc_host_model host_u (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low), .select_n_o(select_n));
  task check(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clock_i) #1;
  endtask
  task wait_ready;
    begin
      for (i = 0; i < 100 && init_pending_o !== 1'b0; i = i + 1) cyc(1);
      check(init_pending_o, 0);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_power_up;
    begin
      check({tx_off, rx_off, init_pending_o}, 9'h1FF);
      check({pres_oe, pres_n}, 8'h02);
      wait_ready;
      cyc(3);
      check(alert_line, 0);
      check(high_power_o, 1);
    end
  endtask
  task t_access;
    begin
      host_u.xfer(0, `PLSC_ADDR_LANE_OFF, 1, 8'h3C, rd, ok);
      check(ok, 0);
      check({rx_off, tx_off}, 8'h00);
      host_u.xfer(1, `PLSC_ADDR_LANE_OFF, 1, 8'hA5, rd, ok);
      check({ok, rx_off, tx_off}, 9'h1A5);
      host_u.xfer(1, `PLSC_ADDR_LANE_OFF, 0, 0, rd, ok);
      check(rd, 8'hA5);
      host_u.xfer(1, `PLSC_ADDR_FLAGS, 0, 0, rd, ok);
      check(rd[1:0], 2'b01);
      cyc(4);
      check(alert_line, 1);
      power_cap_pin_i = 1'b1;
      cyc(4);
      check(high_power_o, 0);
      host_u.xfer(1, `PLSC_ADDR_STATUS, 0, 0, rd, ok);
      check(rd[1:0], 2'b10);
      host_u.xfer(1, `PLSC_ADDR_POWER, 1, 8'h03, rd, ok);
      check({ok, high_power_o}, 2'b11);
    end
  endtask
  task t_restart;
    begin
      hard_restart_n_i = 1'b0;
      cyc(RMIN - 4);
      hard_restart_n_i = 1'b1;
      cyc(6);
      check({init_pending_o, rx_off, tx_off}, 9'h0A5);
      hard_restart_n_i = 1'b0;
      cyc(RMIN + 6);
      check({init_pending_o, rx_off, tx_off}, 9'h1FF);
      hard_restart_n_i = 1'b1;
      wait_ready;
      cyc(3);
      check({alert_line, rx_off, tx_off}, 9'h000);
      check(high_power_o, 0);
      host_u.xfer(1, `PLSC_ADDR_FLAGS, 0, 0, rd, ok);
      check(rd[1:0], 2'b01);
    end
  endtask
  task t_fault;
    begin
      fault_i = 1'b1;
      cyc(6);
      check(alert_line, 0);
      host_u.xfer(1, `PLSC_ADDR_FLAGS, 0, 0, rd, ok);
      check({rd[1], alert_line}, 2'b10);
      fault_i = 1'b0;
      cyc(4);
      host_u.xfer(1, `PLSC_ADDR_FLAGS, 0, 0, rd, ok);
      cyc(4);
      check(alert_line, 1);
    end
  endtask
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = !clock_i;
  end
  // watchdog
  initial begin
    #400000;
    n_fail = n_fail + 1;
    end_sim;
  end
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    reset_i = 1'b1;
    hard_restart_n_i = 1'b1;
    power_cap_pin_i = 1'b0;
    fault_i = 1'b0;
    cyc(12);
    reset_i = 1'b0;
    t_power_up;
    t_access;
    t_restart;
    t_fault;
    end_sim;
  end
endmodule // plsc_low_speed_ctrl_tb
bind plsc_low_speed_ctrl plsc_low_speed_ctrl_checker #(.RESET_MIN_CYC(RESET_MIN_CYC), .INIT_CYC(INIT_CYC),
  .LANES(LANES)) chk_u (.clock_i(clock_i), .reset_i(reset_i), .bus_select_n_i(bus_select_n_i),
  .hard_restart_n_i(hard_restart_n_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .presence_n_o(presence_n_o),
  .presence_n_oe_o(presence_n_oe_o), .alert_n_o(alert_n_o), .alert_n_oe_o(alert_n_oe_o),
  .tx_lane_off_o(tx_lane_off_o), .rx_lane_off_o(rx_lane_off_o), .init_pending_o(init_pending_o));
